// >>> icac_classifier.sv
// io channel alarm classifier: ranges, limits, flow bands, timeouts
// What this block does
// - current under range sets below 3.5 mA, clears above 4 mA.
// - between 3.5 and 4.0 mA, convert fixed 4.0 mA.
// - current over range sets above 20.5 mA, clears below 20 mA.
// - between 20.0 and 20.5 mA convert measured current unclamped.
// - value compared to low-low, low, high, high-high limits.
// - channel failure alarm when data read fails.
// - pressure transmitters deviating over limit raise discrepancy.
// - pressure below lower range value: under range, no flow calculation.
// - pressure above overload limit: over range, clamp, fault totals.
// - per-channel enables for range and four level alarms.
// - temperature below low scale or above high scale flags range.
// - flowrate below cut-off flags cut-off and stops totalizing.
// - flowrate between cut-off and minimum: under range, fault totals.
// - flowrate above maximum, below overload: over range, fault totals.
// - flowrate above factor times maximum: meter overload, fault totals.
// - above 1.5 times that: critical overload, no data, no totals.
// - flowrate is always passed through regardless of totalizing.
// - frequency below low or above high setting flags range.
// - pulse backlog above ten seconds of max frequency: overload.
// - serial value not rewritten within timeout raises timeout alarm.
// - density value outside low or high scale flags range.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "icac_map.svh"
module icac_classifier #(
    parameter int W = 32,
    parameter int CLK_HZ = 40000000
) (
    input wire logic mclk,
    input wire logic nrst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // sample from channel front end (same clock)
    input wire logic sample_valid,
    input wire logic read_fail,
    input wire logic [15:0] loop_ua,
    input wire logic [W-1:0] eng_value,
    input wire logic [W-1:0] peer_value_b,
    input wire logic [W-1:0] peer_value_c,
    input wire logic serial_write,
    input wire logic [W-1:0] pulse_backlog,
    // results
    output logic [15:0] convert_ua,
    output logic [W-1:0] value_out,
    output logic value_valid,
    output logic flow_calc_en,
    output logic totalize_en,
    output logic fault_totals,
    output logic no_data,
    output logic [17:0] alarms
);
    // ------------------------------------------------------------
    // alarm bit positions
    // ------------------------------------------------------------
    localparam int A_UNDER = 0, A_OVER = 1, A_LOW_LOW_LIMIT = 2, A_LO = 3;
    localparam int A_HI = 4, A_HIGH_HIGH_LIMIT = 5, A_FAIL = 6, A_CUT = 7;
    localparam int A_DISC = 8, A_QMIN = 9, A_QMAX = 10, A_OVLD = 11;
    localparam int A_CRIT = 12, A_POVL = 13, A_TMO = 14;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [W-1:0] cfg_q [1:15];
    logic [31:0] tmo_cnt_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `ICAC_CTRL_RST;
            for (int i = 1; i < 16; i++) begin
                cfg_q[i] <= '0;
            end
        end else if (reg_wr) begin
            if (reg_addr == `ICAC_REG_CTRL) begin
                ctrl_q <= reg_wdata;
            end else if (reg_addr != `ICAC_REG_STATUS) begin
                cfg_q[reg_addr] <= reg_wdata[W-1:0];
            end
        end
    end

    icac_pkg::icac_kind_e kind;
    logic [5:0] en;
    logic [1:0] ndp;
    assign kind = icac_pkg::icac_kind_e'(ctrl_q[`ICAC_CTL_KIND_LSB +: 3]);
    assign en = ctrl_q[`ICAC_CTL_EN_LSB +: 6];
    assign ndp = ctrl_q[`ICAC_CTL_NDP_LSB +: 2];

    // ------------------------------------------------------------
    // current loop hysteresis
    // ------------------------------------------------------------
    logic under_h_q, over_h_q;
    logic under_h_d, over_h_d;
    // hysteresis is resolved ahead of the sample edge so that the alarm
    // word latched with a sample already reflects that very sample
    always_comb begin
        under_h_d = under_h_q;
        if (loop_ua < `ICAC_UA_UNDER_SET) begin
            under_h_d = 1'b1;
        end else if (loop_ua > `ICAC_UA_UNDER_CLR) begin
            under_h_d = 1'b0;
        end
    end
    always_comb begin
        over_h_d = over_h_q;
        if (loop_ua > `ICAC_UA_OVER_SET) begin
            over_h_d = 1'b1;
        end else if (loop_ua < `ICAC_UA_OVER_CLR) begin
            over_h_d = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            under_h_q <= 1'b0;
        end else if (sample_valid) begin
            under_h_q <= under_h_d;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            over_h_q <= 1'b0;
        end else if (sample_valid) begin
            over_h_q <= over_h_d;
        end
    end
    // clamp everything below 4.0 mA to 4.0 mA; above 20 mA the raw value passes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            convert_ua <= 16'h0000;
        end else if (sample_valid) begin
            if (loop_ua < `ICAC_UA_CLAMP) begin
                convert_ua <= `ICAC_UA_CLAMP;
            end else begin
                convert_ua <= loop_ua;
            end
        end
    end

    // ------------------------------------------------------------
    // comparisons
    // ------------------------------------------------------------
    function automatic logic [W-1:0] absdiff(input logic [W-1:0] a,
                                             input logic [W-1:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    logic [W+1:0] ovl_lim, crit_lim;
    logic [2*W-1:0] tm_prod;
    logic [W-1:0] v, qmax;
    logic [63:0] backlog_lim;
    assign v = eng_value;
    assign qmax = cfg_q[`ICAC_REG_QMAX];
    assign tm_prod = cfg_q[`ICAC_REG_TMFACT] * qmax;
    assign ovl_lim = tm_prod[W+1:0];
    assign crit_lim = (tm_prod[W+1:0] * (W+2)'(`ICAC_CRIT_NUM))
                      / (W+2)'(`ICAC_CRIT_DEN);
    assign backlog_lim = 64'(cfg_q[`ICAC_REG_FREQMAX]) *
                         64'(`ICAC_BACKLOG_SEC);

    logic disc;
    always_comb begin
        disc = 1'b0;
        if (ndp >= 2'd2 && absdiff(v, peer_value_b) >
                cfg_q[`ICAC_REG_DEVLIM]) begin
            disc = 1'b1;
        end
        if (ndp == 2'd3 && (absdiff(v, peer_value_c) >
                cfg_q[`ICAC_REG_DEVLIM] || absdiff(peer_value_b,
                peer_value_c) > cfg_q[`ICAC_REG_DEVLIM])) begin
            disc = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // classification on each sample
    // ------------------------------------------------------------
    logic [17:0] al_d;
    logic fc_d, tot_d, ft_d, nd_d;
    logic [W-1:0] vo_d;
    always_comb begin
        al_d = '0;
        fc_d = 1'b1;
        tot_d = 1'b0;
        ft_d = 1'b0;
        nd_d = 1'b0;
        vo_d = v;
        al_d[A_LOW_LOW_LIMIT] = v < cfg_q[`ICAC_REG_LOW_LOW_LIMIT];
        al_d[A_LO] = v < cfg_q[`ICAC_REG_LO];
        al_d[A_HI] = v > cfg_q[`ICAC_REG_HI];
        al_d[A_HIGH_HIGH_LIMIT] = v > cfg_q[`ICAC_REG_HIGH_HIGH_LIMIT];
        unique case (kind)
            icac_pkg::KIND_CURRENT: begin
                al_d[A_UNDER] = under_h_d;
                al_d[A_OVER] = over_h_d;
            end
            icac_pkg::KIND_DP: begin
                // a pressure channel feeds totals unless flow calc stops
                tot_d = 1'b1;
                al_d[A_DISC] = disc;
                if (v < cfg_q[`ICAC_REG_LOSCALE]) begin
                    al_d[A_UNDER] = 1'b1;
                    fc_d = 1'b0;
                    tot_d = 1'b0;
                end else if (v < cfg_q[`ICAC_REG_CUTOFF]) begin
                    al_d[A_CUT] = 1'b1;
                    vo_d = '0;
                end else if (v > cfg_q[`ICAC_REG_PMAX]) begin
                    al_d[A_OVER] = 1'b1;
                    vo_d = cfg_q[`ICAC_REG_PMAX];
                    ft_d = 1'b1;
                end
            end
            icac_pkg::KIND_RTD, icac_pkg::KIND_DENSITY,
            icac_pkg::KIND_FLOW_FREQ: begin
                // frequency bounds share the scale registers
                al_d[A_UNDER] = v < cfg_q[`ICAC_REG_LOSCALE];
                al_d[A_OVER] = v > cfg_q[`ICAC_REG_HISCALE];
            end
            icac_pkg::KIND_FLOW_PULSE: begin
                tot_d = 1'b1;
                if ((W+2)'(v) > crit_lim) begin
                    al_d[A_CRIT] = 1'b1;
                    al_d[A_OVLD] = 1'b1;
                    al_d[A_OVER] = 1'b1;
                    al_d[A_QMAX] = 1'b1;
                    nd_d = 1'b1;
                    tot_d = 1'b0;
                end else if ((W+2)'(v) > ovl_lim) begin
                    al_d[A_OVLD] = 1'b1;
                    al_d[A_OVER] = 1'b1;
                    al_d[A_QMAX] = 1'b1;
                    ft_d = 1'b1;
                end else if (v > qmax) begin
                    al_d[A_OVER] = 1'b1;
                    al_d[A_QMAX] = 1'b1;
                    ft_d = 1'b1;
                end else if (v < cfg_q[`ICAC_REG_CUTOFF]) begin
                    al_d[A_CUT] = 1'b1;
                    tot_d = 1'b0;
                end else if (v < cfg_q[`ICAC_REG_QMIN]) begin
                    al_d[A_UNDER] = 1'b1;
                    al_d[A_QMIN] = 1'b1;
                    ft_d = 1'b1;
                end
            end
            icac_pkg::KIND_SERIAL: begin
            end
            default: begin
            end
        endcase
        al_d[A_UNDER] = al_d[A_UNDER] & en[0];
        al_d[A_OVER] = al_d[A_OVER] & en[1];
        al_d[A_LOW_LOW_LIMIT] = al_d[A_LOW_LOW_LIMIT] & en[2];
        al_d[A_LO] = al_d[A_LO] & en[3];
        al_d[A_HI] = al_d[A_HI] & en[4];
        al_d[A_HIGH_HIGH_LIMIT] = al_d[A_HIGH_HIGH_LIMIT] & en[5];
        al_d[A_FAIL] = read_fail;
        if (read_fail) begin
            fc_d = 1'b0;
            tot_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sampled results
    // ------------------------------------------------------------
    logic [12:0] samp_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            samp_q <= '0;
            value_out <= '0;
            flow_calc_en <= 1'b0;
            totalize_en <= 1'b0;
            fault_totals <= 1'b0;
            no_data <= 1'b0;
        end else if (sample_valid) begin
            samp_q <= al_d[12:0];
            value_out <= vo_d;
            flow_calc_en <= fc_d;
            totalize_en <= tot_d;
            fault_totals <= ft_d & tot_d;
            no_data <= nd_d;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            value_valid <= 1'b0;
        end else begin
            value_valid <= sample_valid;
        end
    end

    // ------------------------------------------------------------
    // pulse output backlog and serial update timeout
    // ------------------------------------------------------------
    logic povl_q, tmo_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            povl_q <= 1'b0;
        end else begin
            povl_q <= 64'(pulse_backlog) > backlog_lim;
        end
    end
    // timeout register counts clock cycles
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tmo_cnt_q <= '0;
            tmo_q <= 1'b0;
        end else if (kind != icac_pkg::KIND_SERIAL || serial_write) begin
            tmo_cnt_q <= '0;
            tmo_q <= 1'b0;
        end else if (32'(cfg_q[`ICAC_REG_TIMEOUT]) != 32'h0 &&
                     tmo_cnt_q >= 32'(cfg_q[`ICAC_REG_TIMEOUT])) begin
            tmo_q <= 1'b1;
        end else begin
            tmo_cnt_q <= tmo_cnt_q + 32'h1;
        end
    end
    assign alarms = {3'b000, tmo_q, povl_q, samp_q};

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            if (reg_addr == `ICAC_REG_CTRL) begin
                reg_rdata <= ctrl_q;
            end else if (reg_addr == `ICAC_REG_STATUS) begin
                reg_rdata <= {14'h0, alarms};
            end else begin
                reg_rdata <= 32'(cfg_q[reg_addr]);
            end
        end
    end
endmodule

// >>> icac_map.svh
// constants for the io channel alarm classifier
`ifndef ICAC_MAP_SVH
`define ICAC_MAP_SVH
// current thresholds in microamps
`define ICAC_UA_UNDER_SET 16'h0dac
`define ICAC_UA_UNDER_CLR 16'h0fa0
`define ICAC_UA_OVER_SET 16'h5014
`define ICAC_UA_OVER_CLR 16'h4e20
`define ICAC_UA_CLAMP 16'h0fa0
// critical overload factor 1.5 as 3/2
`define ICAC_CRIT_NUM 3
`define ICAC_CRIT_DEN 2
// pulse output backlog window
`define ICAC_BACKLOG_SEC 10
// control register value out of reset: current kind, all enables on
`define ICAC_CTRL_RST 32'h0000_03f0
// register offsets
`define ICAC_REG_CTRL 4'h0
`define ICAC_REG_LOW_LOW_LIMIT 4'h1
`define ICAC_REG_LO 4'h2
`define ICAC_REG_HI 4'h3
`define ICAC_REG_HIGH_HIGH_LIMIT 4'h4
`define ICAC_REG_LOSCALE 4'h5
`define ICAC_REG_HISCALE 4'h6
`define ICAC_REG_CUTOFF 4'h7
`define ICAC_REG_QMIN 4'h8
`define ICAC_REG_QMAX 4'h9
`define ICAC_REG_TMFACT 4'ha
`define ICAC_REG_DEVLIM 4'hb
`define ICAC_REG_TIMEOUT 4'hc
`define ICAC_REG_PMAX 4'hd
`define ICAC_REG_STATUS 4'he
`define ICAC_REG_FREQMAX 4'hf
// control fields
`define ICAC_CTL_KIND_LSB 0
`define ICAC_CTL_EN_LSB 4
`define ICAC_CTL_NDP_LSB 10
`endif

// >>> icac_pkg.sv
// types for the io channel alarm classifier
package icac_pkg;
    typedef enum logic [2:0] {
        KIND_CURRENT, KIND_DP, KIND_RTD, KIND_FLOW_PULSE,
        KIND_FLOW_FREQ, KIND_DENSITY, KIND_SERIAL
    } icac_kind_e;
endpackage

// >>> icac_classifier_sva.sv
// checker for the io channel alarm classifier ports
`timescale 1ns/100ps
module icac_classifier_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic read_fail,
    input wire logic [15:0] loop_ua,
    input logic [15:0] convert_ua,
    input logic value_valid,
    input logic flow_calc_en,
    input logic totalize_en,
    input logic fault_totals,
    input logic no_data,
    input logic [17:0] alarms
);
    // --------------------------------
    // properties
    // --------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_fail_sample;
        sample_valid && read_fail;
    endsequence
    sequence s_low_sample;
        sample_valid && (loop_ua < 16'h0fa0);
    endsequence
    valid_follow_a: assert property (sample_valid |=> value_valid)
        else $error("no result after a sample");
    valid_cause_a: assert property (
        value_valid |-> $past(sample_valid))
        else $error("result without a sample");
    alarm_hold_a: assert property (
        !sample_valid |=> $stable(alarms[12:0]))
        else $error("sample alarms moved between samples");
    spare_zero_a: assert property (alarms[17:15] == 3'h0)
        else $error("spare alarm bits set");
    fail_flag_a: assert property (s_fail_sample |=>
        alarms[6] && !flow_calc_en && !totalize_en)
        else $error("read failure not flagged");
    clamp_low_a: assert property (
        s_low_sample |=> convert_ua == 16'h0fa0)
        else $error("low current not replaced");
    pass_thru_a: assert property (
        sample_valid && loop_ua >= 16'h0fa0
        |=> convert_ua == $past(loop_ua))
        else $error("measured current altered");
    crit_stop_a: assert property (
        alarms[12] |-> no_data && !totalize_en)
        else $error("critical overload still totalizing");
    fault_tot_a: assert property (fault_totals |-> totalize_en)
        else $error("fault totals without totalizing");
endmodule

bind icac_classifier icac_classifier_chk icac_classifier_chk_inst (
    .mclk(mclk), .nrst(nrst), .sample_valid(sample_valid),
    .read_fail(read_fail), .loop_ua(loop_ua), .convert_ua(convert_ua),
    .value_valid(value_valid), .flow_calc_en(flow_calc_en),
    .totalize_en(totalize_en), .fault_totals(fault_totals),
    .no_data(no_data), .alarms(alarms));

// >>> icac_field_model.sv
// field transmitter model: presents one sample per request
`timescale 1ns/100ps
module icac_field_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req,
    input wire logic slow,
    input wire logic [15:0] req_ua,
    input wire logic [31:0] req_eng,
    input wire logic req_fail,
    input wire logic [31:0] peer_skew,
    output logic sample_valid,
    output logic read_fail,
    output logic [15:0] loop_ua,
    output logic [31:0] eng_value,
    output logic [31:0] peer_value_b,
    output logic [31:0] peer_value_c
);
    // --------------------------------
    // sample launch
    // --------------------------------
    logic pend_q;
    logic [1:0] wait_q;
    // a second transmitter that reads a fixed offset from the first
    assign peer_value_b = eng_value + peer_skew;
    assign peer_value_c = eng_value;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pend_q <= 1'b0;
            wait_q <= 2'h0;
            sample_valid <= 1'b0;
            read_fail <= 1'b0;
            loop_ua <= 16'h0000;
            eng_value <= 32'h0000_0000;
        end else begin
            sample_valid <= 1'b0;
            // outside a sample the lines carry no data, so they toggle
            read_fail <= ~read_fail;
            loop_ua <= ~loop_ua;
            eng_value <= ~eng_value;
            if (req) begin
                pend_q <= 1'b1;
                wait_q <= slow ? 2'h3 : 2'h0;
            end else if (pend_q && wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end else if (pend_q) begin
                pend_q <= 1'b0;
                sample_valid <= 1'b1;
                read_fail <= req_fail;
                loop_ua <= req_ua;
                eng_value <= req_eng;
            end
        end
    end
endmodule

// >>> icac_classifier_tb.sv
// self-checking bench for the io channel alarm classifier
`timescale 1ns/100ps
`include "icac_map.svh"
module icac_classifier_tb;
    typedef struct packed {
        logic [11:0] ctl;
        logic [15:0] ua;
        logic [11:0] eng;
        logic fail;
        logic [13:0] eal;
        logic [13:0] msk;
    } icac_row_s;
    // expected {totalize_en, alarms[12:0]} under a mask
    icac_row_s rows [24] = '{
        '{12'h3f0, 16'h2ee0, 12'h032, 1'h0, 14'h0000, 14'h007f},
        '{12'h3f0, 16'h0d48, 12'h032, 1'h0, 14'h0001, 14'h007f},
        '{12'h3f0, 16'h0ed8, 12'h032, 1'h0, 14'h0001, 14'h007f},
        '{12'h3f0, 16'h0fa0, 12'h032, 1'h0, 14'h0001, 14'h007f},
        '{12'h3f0, 16'h1004, 12'h032, 1'h0, 14'h0000, 14'h007f},
        '{12'h3f0, 16'h0ed8, 12'h032, 1'h0, 14'h0000, 14'h007f},
        '{12'h3f0, 16'h5078, 12'h032, 1'h0, 14'h0002, 14'h007f},
        '{12'h3f0, 16'h4ee8, 12'h032, 1'h0, 14'h0002, 14'h007f},
        '{12'h3f0, 16'h4dbc, 12'h032, 1'h0, 14'h0000, 14'h007f},
        '{12'h3f0, 16'h4ee8, 12'h005, 1'h0, 14'h000c, 14'h007f},
        '{12'h3f0, 16'h2ee0, 12'h00f, 1'h0, 14'h0008, 14'h007f},
        '{12'h3f0, 16'h2ee0, 12'h055, 1'h0, 14'h0010, 14'h007f},
        '{12'h3f0, 16'h2ee0, 12'h05f, 1'h0, 14'h0030, 14'h007f},
        '{12'h3f0, 16'h2ee0, 12'h032, 1'h1, 14'h0040, 14'h0040},
        '{12'h3f3, 16'h2ee0, 12'h005, 1'h0, 14'h0080, 14'h3c80},
        '{12'h3f3, 16'h2ee0, 12'h00f, 1'h0, 14'h2200, 14'h3e80},
        '{12'h3f3, 16'h2ee0, 12'h032, 1'h0, 14'h2000, 14'h3e80},
        '{12'h3f3, 16'h2ee0, 12'h096, 1'h0, 14'h2400, 14'h3e80},
        '{12'h3f3, 16'h2ee0, 12'h0fa, 1'h0, 14'h2800, 14'h3a80},
        '{12'h3f3, 16'h2ee0, 12'h15e, 1'h0, 14'h1000, 14'h3280},
        '{12'h3f2, 16'h2ee0, 12'h003, 1'h0, 14'h000d, 14'h203f},
        '{12'h3f2, 16'h2ee0, 12'h06e, 1'h0, 14'h0032, 14'h203f},
        '{12'h3f5, 16'h2ee0, 12'h003, 1'h0, 14'h000d, 14'h203f},
        '{12'h3f4, 16'h2ee0, 12'h06e, 1'h0, 14'h0032, 14'h203f}};
    logic mclk, nrst, reg_wr, reg_rd, req, slow, req_fail, serial_write;
    logic sample_valid, read_fail, value_valid, flow_calc_en, totalize_en;
    logic fault_totals, no_data;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, req_eng, d, eng_value, peer_value_b;
    logic [31:0] peer_value_c, pulse_backlog, value_out, peer_skew;
    logic [15:0] req_ua, loop_ua, convert_ua;
    logic [17:0] alarms;
    logic [11:0] last;
    int err_count, samples_checked;
    icac_classifier icac_classifier_inst (.mclk(mclk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
        .read_fail(read_fail), .loop_ua(loop_ua), .eng_value(eng_value),
        .peer_value_b(peer_value_b), .peer_value_c(peer_value_c),
        .serial_write(serial_write), .pulse_backlog(pulse_backlog),
        .convert_ua(convert_ua), .value_out(value_out),
        .value_valid(value_valid), .flow_calc_en(flow_calc_en),
        .totalize_en(totalize_en), .fault_totals(fault_totals),
        .no_data(no_data), .alarms(alarms));
    icac_field_model icac_field_model_inst (.mclk(mclk), .nrst(nrst),
        .req(req), .slow(slow), .req_ua(req_ua), .req_eng(req_eng),
        .req_fail(req_fail), .peer_skew(peer_skew),
        .sample_valid(sample_valid),
        .read_fail(read_fail), .loop_ua(loop_ua), .eng_value(eng_value),
        .peer_value_b(peer_value_b), .peer_value_c(peer_value_c));
    // --------------------------------
    // tasks
    // --------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic send(input logic [15:0] u, input logic [31:0] e,
                        input logic f);
        int n;
        @(posedge mclk);
        req <= 1'b1;
        req_ua <= u;
        req_eng <= e;
        req_fail <= f;
        @(posedge mclk);
        req <= 1'b0;
        n = 0;
        while (value_valid !== 1'b1 && n < 10) begin
            @(posedge mclk);
            #1 n++;
        end
        chk({31'h0, value_valid}, 32'h1);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // --------------------------------
    // stimulus
    // --------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        repeat (6000) @(posedge mclk);
        err_count++;
        results();
    end
    initial begin
        {nrst, reg_wr, reg_rd, req, slow, req_fail, serial_write} = 7'h00;
        {reg_addr, reg_wdata, req_ua, req_eng, pulse_backlog, peer_skew} = '0;
        last = 12'h3f0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        rd(`ICAC_REG_CTRL, d);
        chk(d, 32'h3f0);
        wr(`ICAC_REG_LOW_LOW_LIMIT, 32'ha);
        wr(`ICAC_REG_LO, 32'h14);
        wr(`ICAC_REG_HI, 32'h50);
        wr(`ICAC_REG_HIGH_HIGH_LIMIT, 32'h5a);
        wr(`ICAC_REG_CUTOFF, 32'ha);
        wr(`ICAC_REG_QMIN, 32'h14);
        wr(`ICAC_REG_QMAX, 32'h64);
        wr(`ICAC_REG_TMFACT, 32'h2);
        wr(`ICAC_REG_FREQMAX, 32'h64);
        wr(`ICAC_REG_TIMEOUT, 32'h14);
        wr(`ICAC_REG_LOSCALE, 32'h5);
        wr(`ICAC_REG_HISCALE, 32'h64);
        wr(`ICAC_REG_PMAX, 32'h64);
        wr(`ICAC_REG_DEVLIM, 32'h5);
        rd(`ICAC_REG_LOW_LOW_LIMIT, d);
        chk(d, 32'ha);
        $display("test registers done");
        foreach (rows[i]) begin
            if (rows[i].ctl != last) wr(`ICAC_REG_CTRL, {20'h0, rows[i].ctl});
            last = rows[i].ctl;
            @(posedge mclk);
            slow <= i[0];
            send(rows[i].ua, {20'h0, rows[i].eng}, rows[i].fail);
            chk({18'h0, {totalize_en, alarms[12:0]} & rows[i].msk},
                {18'h0, rows[i].eal});
            if (rows[i].ctl[2:0] == 3'h0)
                chk({16'h0, convert_ua}, {16'h0, rows[i].ua < 16'h0fa0 ?
                    16'h0fa0 : rows[i].ua});
            else
                chk(value_out, {20'h0, rows[i].eng});
        end
        $display("test rows done");
        wr(`ICAC_REG_CTRL, 32'hbf1);
        peer_skew <= 32'h3;
        send(16'h2ee0, 32'h3, 1'b0);
        chk({28'h0, alarms[8], alarms[0], flow_calc_en, totalize_en},
            32'h4);
        send(16'h2ee0, 32'h8, 1'b0);
        chk({alarms[7], value_out[30:0]}, 32'h8000_0000);
        send(16'h2ee0, 32'h78, 1'b0);
        chk({alarms[1], fault_totals, value_out[29:0]},
            32'hc000_0064);
        @(posedge mclk);
        peer_skew <= 32'h6;
        send(16'h2ee0, 32'h32, 1'b0);
        chk({31'h0, alarms[8]}, 32'h1);
        $display("test pressure done");
        wr(`ICAC_REG_CTRL, 32'h0);
        send(16'h0d48, 32'h5, 1'b0);
        chk({26'h0, alarms[5:0]}, 32'h0);
        $display("test enables done");
        @(posedge mclk);
        pulse_backlog <= 32'h3e8;
        repeat (3) @(posedge mclk);
        #1 chk({31'h0, alarms[13]}, 32'h0);
        @(posedge mclk);
        pulse_backlog <= 32'h3e9;
        repeat (3) @(posedge mclk);
        #1 chk({31'h0, alarms[13]}, 32'h1);
        $display("test backlog done");
        wr(`ICAC_REG_CTRL, 32'h3f6);
        serial_write <= 1'b1;
        @(posedge mclk);
        serial_write <= 1'b0;
        repeat (10) @(posedge mclk);
        #1 chk({31'h0, alarms[14]}, 32'h0);
        repeat (15) @(posedge mclk);
        #1 chk({31'h0, alarms[14]}, 32'h1);
        @(posedge mclk);
        serial_write <= 1'b1;
        @(posedge mclk);
        serial_write <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk({31'h0, alarms[14]}, 32'h0);
        $display("test timeout done");
        results();
    end
endmodule
